/* File: design/autoneg_advert_register.sv */
// auto-negotiation advertisement register for one port
// ============================================================
// Summary of operation
// R1: register is 16 bits wide at management index 4.
// R2: bits 4:0 selector, writable, reset value 00001.
// R3: bit 13 remote fault advertise, writable, resets to 0.
// R4: software writes 0 to reserved bit 12.
// R5: bit 11 writable asymmetric pause advertise.
// R6: bit 10 defaults to inverse of manual flow control strap.
// R7: bit 8 100BASE-X full duplex, writable, resets to 1.
// R8: bit 7 100BASE-X half duplex, writable, resets to 1.
// R9: bit 6 default = autoneg OR (NOT speed AND duplex).
// R10: bit 5 default = autoneg OR NOT speed.
// R11: straps are latched at reset release, defaults come from them.
// R12: loader overwrites register after reset release and reload.
// R13: loader supplies symmetric and asymmetric pause values.
// R14: bits 15, 14 and 9 read 0 and ignore writes.
`timescale 1ns/100ps
`default_nettype none
`include "autoneg_adv_consts.svh"
module autoneg_advert_register
	import autoneg_adv_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// configuration strap pins
	input wire strap_t STRAPS,
	// management register port
	input wire mgmt_req_t MGMT,
	output logic [15:0] RDATA,
	// eeprom loader
	input wire loader_t LOADER,
	// advertised abilities toward negotiation logic
	output logic [15:0] ADVERT,
	output logic STRAPS_VALID
);
	// ============================================================
	// strap capture
	strap_t straps_s;
	strap_t straps_q;
	init_state_t state_q;
	logic [15:0] adv_q;
	logic [15:0] adv_d;
	logic warm_q;

	strap_sync u_sync (
		.clk(CLK),
		.resetn(RESETN),
		.pins(STRAPS),
		.synced(straps_s)
	);

	function automatic logic [15:0] strap_default(input strap_t s);
		logic [15:0] v;
		v = `ADV_FIXED_RESET; // R2 R7 R8 R3
		v[`ADV_SYM_BIT] = ~s.manual_flow_ctrl; // R6
		v[`ADV_T_FD_BIT] = s.autoneg | (~s.speed & s.duplex); // R9
		v[`ADV_T_HD_BIT] = s.autoneg | ~s.speed; // R10
		return v;
	endfunction

	// synchroniser still shows its reset value one edge after release
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			warm_q <= 1'b0;
		end else begin
			warm_q <= 1'b1;
		end
	end

	// waits for the synchroniser to fill, then latches once
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= ST_RESET;
		end else begin
			case (state_q)
				ST_RESET: begin
					if (warm_q) begin
						state_q <= ST_LATCH;
					end
				end
				ST_LATCH: state_q <= ST_RUN;
				ST_RUN: state_q <= ST_RUN;
				default: state_q <= ST_RESET;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			straps_q <= '0;
		end else if (state_q == ST_LATCH) begin
			straps_q <= straps_s; // R11
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			STRAPS_VALID <= 1'b0;
		end else begin
			STRAPS_VALID <= (state_q == ST_LATCH) | STRAPS_VALID;
		end
	end

	// ============================================================
	// register contents
	wire logic hit = (MGMT.addr == `ADV_INDEX); // R1
	always_comb begin
		adv_d = adv_q;
		if (state_q == ST_LATCH) begin
			adv_d = strap_default(straps_s); // R11
		end else if (LOADER.load) begin
			adv_d = LOADER.word & `ADV_WMASK; // R12
			adv_d[`ADV_SYM_BIT] = LOADER.sym_pause; // R13
			adv_d[`ADV_ASYM_BIT] = LOADER.asym_pause; // R13
		end else if (MGMT.wr && hit) begin
			// R2 R3 R5 R14
			adv_d = MGMT.wdata & `ADV_WMASK;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			adv_q <= `ADV_FIXED_RESET;
		end else begin
			adv_q <= adv_d;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ADVERT <= `ADV_FIXED_RESET;
		end else begin
			ADVERT <= adv_d;
		end
	end

	// ============================================================
	// read port
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RDATA <= 16'h0000;
		end else if (MGMT.rd && hit) begin
			RDATA <= adv_q & `ADV_WMASK; // R14
		end else begin
			RDATA <= 16'h0000;
		end
	end

	// ============================================================
	// checks
	property p_reserved_zero;
		@(posedge CLK) disable iff (!RESETN)
		(ADVERT[15:14] == 2'b00) && (ADVERT[9] == 1'b0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // R14
		else $error("reserved advert bits set");

	property p_write_takes;
		@(posedge CLK) disable iff (!RESETN)
		(MGMT.wr && hit && !LOADER.load && state_q == ST_RUN) |=>
			(adv_q == ($past(MGMT.wdata) & `ADV_WMASK));
	endproperty
	a_write_takes: assert property (p_write_takes) // R3
		else $error("write not stored");

	property p_read_data;
		@(posedge CLK) disable iff (!RESETN)
		(MGMT.rd && hit) |=> (RDATA == ($past(adv_q) & `ADV_WMASK));
	endproperty
	a_read_data: assert property (p_read_data) // R1
		else $error("read data mismatch");

	property p_read_idle;
		@(posedge CLK) disable iff (!RESETN)
		!(MGMT.rd && hit) |=> (RDATA == 16'h0000);
	endproperty
	a_read_idle: assert property (p_read_idle) // R1
		else $error("read data not zero");

	property p_loader_pause;
		@(posedge CLK) disable iff (!RESETN)
		(LOADER.load && state_q == ST_RUN) |=>
			(adv_q[`ADV_SYM_BIT] == $past(LOADER.sym_pause)) &&
			(adv_q[`ADV_ASYM_BIT] == $past(LOADER.asym_pause));
	endproperty
	a_loader_pause: assert property (p_loader_pause) // R13
		else $error("loader pause bits lost");

	property p_default_sym;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == ST_LATCH) |=>
			(adv_q[`ADV_SYM_BIT] == ~straps_q.manual_flow_ctrl) &&
			(adv_q[`ADV_T_HD_BIT] == (straps_q.autoneg | ~straps_q.speed));
	endproperty
	a_default_sym: assert property (p_default_sym) // R6
		else $error("strap default wrong");

	property p_default_tfd;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == ST_LATCH) |=>
			adv_q[`ADV_T_FD_BIT] ==
			(straps_q.autoneg | (~straps_q.speed & straps_q.duplex));
	endproperty
	a_default_tfd: assert property (p_default_tfd) // R9
		else $error("10 full duplex default wrong");

	property p_default_fixed;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == ST_LATCH) |=>
			(adv_q[4:0] == `ADV_SEL_RESET) && adv_q[`ADV_FX_FD_BIT] &&
			adv_q[`ADV_FX_HD_BIT] && !adv_q[`ADV_RF_BIT];
	endproperty
	a_default_fixed: assert property (p_default_fixed) // R2
		else $error("fixed default wrong");

	property p_startup;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == ST_LATCH) |=> (state_q == ST_RUN) && STRAPS_VALID;
	endproperty
	a_startup: assert property (p_startup) // R11
		else $error("strap latch sequence wrong");

	property p_reset_exit;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == ST_RESET) |-> ##[1:3] (state_q == ST_LATCH);
	endproperty
	a_reset_exit: assert property (p_reset_exit) // R11
		else $error("strap latch never reached");

	property p_advert_mirror;
		@(posedge CLK) disable iff (!RESETN)
		ADVERT == adv_q;
	endproperty
	a_advert_mirror: assert property (p_advert_mirror) // R1
		else $error("advert differs from register");

	property p_hold;
		@(posedge CLK) disable iff (!RESETN)
		(!(MGMT.wr && hit) && !LOADER.load && state_q == ST_RUN) |=>
			$stable(adv_q);
	endproperty
	a_hold: assert property (p_hold) // R1
		else $error("register changed without a write");

	property p_rsv_read;
		@(posedge CLK) disable iff (!RESETN)
		(MGMT.rd && hit) |=>
			(RDATA[15:14] == 2'b00) && !RDATA[9];
	endproperty
	a_rsv_read: assert property (p_rsv_read) // R14
		else $error("reserved read bits set");

	property p_write_sel;
		@(posedge CLK) disable iff (!RESETN)
		(MGMT.wr && hit && !LOADER.load && state_q == ST_RUN) |=>
			(adv_q[4:0] == $past(MGMT.wdata[4:0]));
	endproperty
	a_write_sel: assert property (p_write_sel) // R2
		else $error("selector write not stored");

	property p_write_asym;
		@(posedge CLK) disable iff (!RESETN)
		(MGMT.wr && hit && !LOADER.load && state_q == ST_RUN) |=>
			(adv_q[`ADV_ASYM_BIT] == $past(MGMT.wdata[`ADV_ASYM_BIT]));
	endproperty
	a_write_asym: assert property (p_write_asym) // R5
		else $error("asymmetric pause write not stored");

	property p_write_fxfd;
		@(posedge CLK) disable iff (!RESETN)
		(MGMT.wr && hit && !LOADER.load && state_q == ST_RUN) |=>
			(adv_q[`ADV_FX_FD_BIT] == $past(MGMT.wdata[`ADV_FX_FD_BIT]));
	endproperty
	a_write_fxfd: assert property (p_write_fxfd) // R7
		else $error("100 full duplex write not stored");

	property p_write_fxhd;
		@(posedge CLK) disable iff (!RESETN)
		(MGMT.wr && hit && !LOADER.load && state_q == ST_RUN) |=>
			(adv_q[`ADV_FX_HD_BIT] == $past(MGMT.wdata[`ADV_FX_HD_BIT]));
	endproperty
	a_write_fxhd: assert property (p_write_fxhd) // R8
		else $error("100 half duplex write not stored");

	property p_default_thd;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == ST_LATCH) |=>
			adv_q[`ADV_T_HD_BIT] == (straps_q.autoneg | ~straps_q.speed);
	endproperty
	a_default_thd: assert property (p_default_thd) // R10
		else $error("10 half duplex default wrong");

	property p_default_fxfd;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == ST_LATCH) |=>
			adv_q[`ADV_FX_FD_BIT];
	endproperty
	a_default_fxfd: assert property (p_default_fxfd) // R7
		else $error("100 full duplex default wrong");

	property p_default_fxhd;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == ST_LATCH) |=>
			adv_q[`ADV_FX_HD_BIT];
	endproperty
	a_default_fxhd: assert property (p_default_fxhd) // R8
		else $error("100 half duplex default wrong");

	property p_default_rf;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == ST_LATCH) |=>
			!adv_q[`ADV_RF_BIT];
	endproperty
	a_default_rf: assert property (p_default_rf) // R3
		else $error("remote fault default wrong");

	property p_latch_straps;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == ST_LATCH) |=>
			(straps_q == $past(straps_s));
	endproperty
	a_latch_straps: assert property (p_latch_straps) // R11
		else $error("straps not captured");

	property p_valid_sticky;
		@(posedge CLK) disable iff (!RESETN)
		STRAPS_VALID |=>
			STRAPS_VALID;
	endproperty
	a_valid_sticky: assert property (p_valid_sticky) // R11
		else $error("strap valid dropped");

	property p_run_valid;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == ST_RUN) |-> STRAPS_VALID;
	endproperty
	a_run_valid: assert property (p_run_valid) // R11
		else $error("running without strap capture");

	property p_loader_word;
		@(posedge CLK) disable iff (!RESETN)
		(LOADER.load && state_q == ST_RUN) |=>
			((adv_q & `ADV_LOAD_WORD_MASK) ==
			($past(LOADER.word) & `ADV_LOAD_WORD_MASK));
	endproperty
	a_loader_word: assert property (p_loader_word) // R12
		else $error("loader word not stored");

	property p_load_wins;
		@(posedge CLK) disable iff (!RESETN)
		(LOADER.load && MGMT.wr && hit && state_q == ST_RUN) |=>
			(adv_q[`ADV_RF_BIT] == $past(LOADER.word[`ADV_RF_BIT]));
	endproperty
	a_load_wins: assert property (p_load_wins) // R12
		else $error("write beat the loader");
endmodule
`default_nettype wire

/* File: common/autoneg_adv_consts.svh */
// constants for the auto-negotiation advertisement register
`ifndef AUTONEG_ADV_CONSTS_SVH
`define AUTONEG_ADV_CONSTS_SVH
`define ADV_INDEX 5'h04
`define ADV_RF_BIT 13
`define ADV_RSV12_BIT 12
`define ADV_ASYM_BIT 11
`define ADV_SYM_BIT 10
`define ADV_FX_FD_BIT 8
`define ADV_FX_HD_BIT 7
`define ADV_T_FD_BIT 6
`define ADV_T_HD_BIT 5
`define ADV_SEL_RESET 5'h01
`define ADV_WMASK 16'h3DFF
`define ADV_FIXED_RESET 16'h0181
`define ADV_LOAD_WORD_MASK 16'h31FF
`endif

/* File: common/autoneg_adv_pkg.sv */
// types for the auto-negotiation advertisement register
`default_nettype none
package autoneg_adv_pkg;
	typedef struct packed {
		logic autoneg;
		logic speed;
		logic duplex;
		logic manual_flow_ctrl;
	} strap_t;
	typedef struct packed {
		logic [4:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} mgmt_req_t;
	typedef struct packed {
		logic load;
		logic sym_pause;
		logic asym_pause;
		logic [15:0] word;
	} loader_t;
	typedef enum logic [2:0] {
		ST_RESET = 3'b001,
		ST_LATCH = 3'b010,
		ST_RUN = 3'b100
	} init_state_t;
endpackage
`default_nettype wire

/* File: design/strap_sync.sv */
// two-flop synchroniser for the strap pins
`timescale 1ns/100ps
`default_nettype none
module strap_sync
	import autoneg_adv_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire strap_t pins,
	output strap_t synced
);
	strap_t meta_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			synced <= '0;
		end else begin
			meta_q <= pins;
			synced <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* File: dv/loader_model.sv */
// eeprom loader stand-in that sends one load pulse on request
`timescale 1ns/100ps
`default_nettype none
module loader_model
	import autoneg_adv_pkg::*;
(
	// clock
	input wire logic CLK,
	// request from the bench: pause bits above the word
	input wire logic GO,
	input wire logic [17:0] IMAGE,
	// loader port
	output loader_t LOADER
);
	logic go_q = 1'b0;
	logic [17:0] img_q = '0;
	always @(posedge CLK) begin
		go_q <= GO;
		img_q <= IMAGE;
	end
	assign LOADER = {go_q, img_q};
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the advertisement register
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import autoneg_adv_pkg::*;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	strap_t STRAPS = '0;
	mgmt_req_t MGMT = '0;
	logic GO = 1'b0;
	logic [17:0] IMAGE = '0;
	loader_t LOADER;
	logic [15:0] RDATA;
	logic [15:0] ADVERT;
	logic [15:0] e;
	logic STRAPS_VALID;
	int fail_count = 0;
	int comparisons = 0;
	// strap nibble {autoneg,speed,duplex,manual} above the expected word
	logic [19:0] rows [16] = '{
		20'h005A1, 20'h101A1, 20'h205E1, 20'h301E1,
		20'h40581, 20'h50181, 20'h60581, 20'h70181,
		20'h805E1, 20'h901E1, 20'hA05E1, 20'hB01E1,
		20'hC05E1, 20'hD01E1, 20'hE05E1, 20'hF01E1
	};
	initial forever #4 CLK = ~CLK;
	autoneg_advert_register dut (.CLK(CLK), .RESETN(RESETN),
		.STRAPS(STRAPS), .MGMT(MGMT), .RDATA(RDATA), .LOADER(LOADER),
		.ADVERT(ADVERT), .STRAPS_VALID(STRAPS_VALID));
	loader_model ldr (.CLK(CLK), .GO(GO), .IMAGE(IMAGE), .LOADER(LOADER));
	// ========
	// helpers
	task chk(input logic [15:0] seen, input logic [15:0] want);
		comparisons++;
		if (seen !== want) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task tally_and_finish;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task do_reset;
		int n;
		@(posedge CLK) RESETN <= 1'b0;
		repeat (6) @(posedge CLK);
		#1 chk(ADVERT, 16'h0181);
		chk({15'h0000, STRAPS_VALID}, 16'h0000);
		@(posedge CLK) RESETN <= 1'b1;
		n = 0;
		while (STRAPS_VALID !== 1'b1) begin
			@(posedge CLK);
			#1 n++;
			if (n > 8) begin
				fail_count++;
				tally_and_finish();
			end
		end
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge CLK) MGMT <= '{a, d, 1'b1, 1'b0};
		@(posedge CLK) MGMT <= '0;
	endtask
	task rd(input logic [4:0] a, input logic [15:0] want);
		@(posedge CLK) MGMT <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge CLK) MGMT <= '0;
		#1 chk(RDATA, want);
		@(posedge CLK) #1 chk(RDATA, 16'h0000);
	endtask
	// ========
	// main sequence
	initial begin
		for (int i = 0; i < 16; i++) begin
			@(posedge CLK) STRAPS <= strap_t'(rows[i][19:16]);
			e = rows[i][15:0];
			do_reset();
			chk(ADVERT, e);
			rd(5'h04, e);
		end
		$display("strap default cases done");
		wr(5'h04, 16'hEFFF);
		rd(5'h04, 16'h2DFF);
		wr(5'h05, 16'h0000);
		rd(5'h05, 16'h0000);
		chk(ADVERT, 16'h2DFF);
		$display("register access done");
		@(posedge CLK) begin
			GO <= 1'b1;
			IMAGE <= {2'b10, 16'hFFFF};
		end
		@(posedge CLK) GO <= 1'b0;
		@(posedge CLK) #1 chk(ADVERT, 16'h35FF);
		rd(5'h04, 16'h35FF);
		// load and software write in one cycle: the load wins
		@(posedge CLK) begin
			GO <= 1'b1;
			IMAGE <= {2'b01, 16'h2000};
		end
		@(posedge CLK) begin
			GO <= 1'b0;
			MGMT <= '{5'h04, 16'h0000, 1'b1, 1'b0};
		end
		@(posedge CLK) MGMT <= '0;
		#1 chk(ADVERT, 16'h2800);
		$display("loader overwrite done");
		do_reset();
		chk(ADVERT, 16'h01E1);
		$display("second reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
